// >>> logic/i2c_clock_count_data_path.sv
// Two-wire master clock, word counter and data path
// Operation
// R1: Master serial clock comes only from dividing the module clock.
// R2: Low phase lasts low divider plus 6 module clock periods.
// R3: High phase lasts high divider plus 6 module clock periods.
// R4: Software sets both dividers only while the module is in reset.
// R5: Count write loads a hidden down-counter; visible count stays unchanged.
// R6: With stop requested, finish with STOP when hidden count hits zero.
// R7: Count zero loads 65536; other values load themselves.
// R8: Repeat mode ignores the word count completely.
// R9: Data pin bits shift into hidden receiver, then copy to holding.
// R10: Short received words sit right-aligned; upper bits are undefined.
// R11: Software writes short transmit words right-aligned.
// R12: Transmit holding is copied into a hidden shifter driving data.
// R13: Shift registers are never reachable through register accesses.
// R14: Target address starts transfers only with free format off.
// R15: Address zero is a general call; nonzero selects one slave.
// R16: 7-bit mode sends bits 6-0; 10-bit mode sends bits 9-0.
// R17: Reserved upper bits read zero and ignore writes.
// R18: Bit count 0 means 8 bits; 1 to 7 mean themselves.
// R19: Nonrepeat, no stop: raise access ready when count hits zero.
// R20: Each generated START reloads the hidden counter from the count.
// R21: Low and high phases alternate continuously while mastering; the code holds the clock low in hold and during a receive stall.
`timescale 1ns/100ps
`include "i2c_defs.svh"
module i2c_clock_count_data_path
	import i2c_pkg::*;
(
	input  wire logic          clock_i,
	input  wire logic          rst_i,
	input  wire reg_req_t      reg_req_i,
	output logic        [31:0] reg_rdata_o,
	input  wire mode_control_t mode_i,
	input  wire logic          start_request_i,
	input  wire logic          scl_i,
	output logic               scl_o,
	output logic               scl_oe_n_o,
	input  wire logic          sda_i,
	output logic               sda_o,
	output logic               sda_oe_n_o,
	output logic               access_ready_o,
	output logic               rx_ready_o,
	output logic               busy_o
);
	////////////////////////////////////////////////////////////////////
	function automatic logic [16:0] phase_len(input logic [15:0] d);
		return {1'b0, d} + `PHASE_EXTRA;
	endfunction

	function automatic logic [16:0] count_start(input logic [15:0] c);
		return (c == 16'h0000) ? `CNT_FULL : {1'b0, c};
	endfunction

	////////////////////////////////////////////////////////////////////
	logic [15:0] low_div;
	logic [15:0] high_div;
	logic [15:0] word_count;
	logic [9:0]  target_address;
	logic [7:0]  transmit_holding;
	logic [7:0]  receive_holding;
	logic        rx_full;
	logic [16:0] hidden_cnt;
	logic [7:0]  transmit_shifter;
	logic [7:0]  receive_shifter;
	logic [3:0]  bits_left;
	eng_state_t  state;
	eng_state_t  next_state;
	word_kind_t  kind;
	word_kind_t  next_kind;
	logic        scl_lvl;
	logic        sda_rel;
	logic [16:0] ph_cnt;
	logic [2:0]  sda_sy;
	logic        sda_s;
	logic [2:0]  scl_sy;
	logic        scl_s;
	logic        buf_in_ready;
	logic        buf_out_valid;
	logic [7:0]  buf_out_data;

	////////////////////////////////////////////////////////////////////
	wire        enabled    = mode_i.module_reset_bit;
	wire        wr_low     = reg_req_i.wr && reg_req_i.sel == `REG_LOW_DIV;
	wire        wr_high    = reg_req_i.wr && reg_req_i.sel == `REG_HIGH_DIV;
	wire        wr_cnt     = reg_req_i.wr && reg_req_i.sel == `REG_WORD_CNT;
	wire        wr_target  = reg_req_i.wr && reg_req_i.sel == `REG_TARGET;
	wire        wr_tx      = reg_req_i.wr && reg_req_i.sel == `REG_TX_HOLD;
	wire        rd_rx      = reg_req_i.rd && reg_req_i.sel == `REG_RX_HOLD;
	// R4: dividers are read live, so mid-transfer writes distort a phase
	wire [16:0] low_len    = phase_len(low_div);
	wire [16:0] high_len   = phase_len(high_div);
	wire        running    = state != ST_IDLE && state != ST_HOLD;
	wire        start_go   = start_request_i & enabled & mode_i.master_select;
	wire        cur_tx     = kind != WK_DATA || mode_i.transmit_select;
	wire        rx_word    = ~cur_tx;
	// Receiver stall holds the clock low rather than dropping a word
	wire        stall      = state == ST_ACK && rx_word && !buf_in_ready;
	// R2: low phase ends after low divider plus 6 cycles
	wire        low_end    = running && !scl_lvl && !stall
	                         && ph_cnt == low_len - 17'h00001;
	// R3: high phase ends after high divider plus 6 cycles
	wire        high_end   = running && scl_lvl
	                         && ph_cnt == high_len - 17'h00001;
	wire        word_end   = high_end && state == ST_ACK;
	wire        data_end   = word_end && kind == WK_DATA;
	// R8: repeat mode never ends on the count
	wire        last_word  = !mode_i.repeat_select
	                         && hidden_cnt == 17'h00001;
	// R18: zero selects a full eight-bit word
	wire [3:0]  data_len   = (mode_i.word_bit_count == 3'h0) ? `DATA_BITS
	                         : {1'b0, mode_i.word_bit_count};
	// R11: short transmit words arrive right-aligned, so lift them to top
	wire [7:0]  tx_aligned = transmit_holding << (`DATA_BITS - data_len);
	// R16: seven-bit form drops bits 9-7, ten-bit form sends all
	// R15: address zero goes out unchanged as a general call
	wire [7:0]  addr_first = mode_i.ten_bit_address_select
	                         ? {`TEN_BIT_PREFIX, target_address[9:8],
	                            ~mode_i.transmit_select}
	                         : {target_address[6:0], ~mode_i.transmit_select};
	wire [7:0]  next_shift = (next_kind == WK_ADDR1) ? addr_first
	                         : (next_kind == WK_ADDR2) ? target_address[7:0]
	                         : tx_aligned;
	wire        next_tx    = next_kind != WK_DATA || mode_i.transmit_select;
	wire        enter_bits = next_state == ST_BITS && state != ST_BITS;
	wire        buf_push   = word_end && rx_word;
	wire        buf_pop    = buf_out_valid && (!rx_full || rd_rx);
	wire        ack_drive  = rx_word && !last_word;
	// R17: reserved bits always read as zero
	wire [31:0] rd_mux     =
		(reg_req_i.sel == `REG_LOW_DIV)  ? {16'h0000, low_div} :
		(reg_req_i.sel == `REG_HIGH_DIV) ? {16'h0000, high_div} :
		(reg_req_i.sel == `REG_WORD_CNT) ? {16'h0000, word_count} :
		(reg_req_i.sel == `REG_RX_HOLD)  ? {24'h000000, receive_holding} :
		(reg_req_i.sel == `REG_TARGET)   ? {22'h0, target_address} :
		(reg_req_i.sel == `REG_TX_HOLD)  ? {24'h000000, transmit_holding} :
		32'h00000000;

	// Open-drain pins only ever pull low
	assign scl_o      = 1'b0;
	assign sda_o      = 1'b0;
	assign scl_oe_n_o = scl_lvl;
	assign sda_oe_n_o = sda_rel;

	////////////////////////////////////////////////////////////////////
	// Bus pin synchronisers
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			sda_sy <= 3'h7;
			scl_sy <= 3'h7;
			sda_s  <= 1'b1;
			scl_s  <= 1'b1;
		end else begin
			sda_sy <= {sda_sy[1:0], sda_i};
			scl_sy <= {scl_sy[1:0], scl_i};
			if (sda_sy[2] == sda_sy[1])
				sda_s <= sda_sy[2];
			if (scl_sy[2] == scl_sy[1])
				scl_s <= scl_sy[2];
		end
	end

	////////////////////////////////////////////////////////////////////
	// Registers; R13: shifters have no decode and cannot be reached
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			low_div          <= `DIV_RESET;
			high_div         <= `DIV_RESET;
			word_count       <= `CNT_RESET;
			target_address   <= 10'h000;
			transmit_holding <= 8'h00;
			reg_rdata_o      <= 32'h00000000;
		end else begin
			// R17: upper bits of write data are dropped
			if (wr_low)
				low_div <= reg_req_i.wdata[15:0];
			if (wr_high)
				high_div <= reg_req_i.wdata[15:0];
			if (wr_cnt)
				word_count <= reg_req_i.wdata[15:0];
			if (wr_target)
				target_address <= reg_req_i.wdata[9:0];
			if (wr_tx)
				transmit_holding <= reg_req_i.wdata[7:0];
			reg_rdata_o <= rd_mux;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Transfer sequencer
	always_comb begin
		next_state = state;
		next_kind  = kind;
		case (state)
			ST_IDLE:
				if (start_go)
					next_state = ST_START;
			ST_HOLD:
				if (start_go)
					next_state = ST_RSTART;
				else if (mode_i.stop_request)
					next_state = ST_STOP;
			ST_RSTART:
				if (high_end)
					next_state = ST_START;
			ST_START:
				if (high_end) begin
					next_state = ST_BITS;
					// R14: address phase only with free format off
					next_kind  = mode_i.free_format_select ? WK_DATA
					             : WK_ADDR1;
				end
			ST_BITS:
				if (high_end && bits_left == 4'h1)
					next_state = ST_ACK;
			ST_ACK:
				if (word_end) begin
					next_state = ST_BITS;
					if (kind == WK_ADDR1 && mode_i.ten_bit_address_select)
						next_kind = WK_ADDR2;
					else if (kind != WK_DATA)
						next_kind = WK_DATA;
					// R6: count exhausted with stop requested ends in STOP
					else if (last_word && mode_i.stop_request)
						next_state = ST_STOP;
					// R19: count exhausted without stop parks the bus
					else if (last_word)
						next_state = ST_HOLD;
					else if (mode_i.repeat_select && mode_i.stop_request)
						next_state = ST_STOP;
				end
			ST_STOP:
				if (high_end)
					next_state = ST_IDLE;
			default:
				next_state = ST_IDLE;
		endcase
	end

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			state <= ST_IDLE;
			kind  <= WK_ADDR1;
		end else if (!enabled) begin
			state <= ST_IDLE;
			kind  <= WK_ADDR1;
		end else begin
			state <= next_state;
			kind  <= next_kind;
		end
	end

	////////////////////////////////////////////////////////////////////
	// R1: clock derived only from module clock counts
	// R21: phases alternate until stop or hold
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			scl_lvl <= 1'b1;
			ph_cnt  <= 17'h00000;
		end else if (!enabled || next_state == ST_IDLE) begin
			scl_lvl <= 1'b1;
			ph_cnt  <= 17'h00000;
		end else if (state == ST_IDLE || state == ST_HOLD) begin
			scl_lvl <= state == ST_IDLE;
			ph_cnt  <= 17'h00000;
		end else if (low_end) begin
			scl_lvl <= 1'b1;
			ph_cnt  <= 17'h00000;
		end else if (high_end) begin
			scl_lvl <= state == ST_RSTART;
			ph_cnt  <= 17'h00000;
		end else if (!stall) begin
			ph_cnt  <= ph_cnt + 17'h00001;
		end
	end

	// Data pin drive; bits change with the falling clock edge, START and STOP while the clock is high
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i)
			sda_rel <= 1'b1;
		else if (!enabled)
			sda_rel <= 1'b1;
		else if (next_state == ST_STOP || next_state == ST_START)
			sda_rel <= 1'b0;
		else if (enter_bits)
			sda_rel <= !next_tx | next_shift[7];
		else if (state == ST_BITS && high_end)
			sda_rel <= (next_state == ST_ACK) ? !ack_drive
			           : !cur_tx | transmit_shifter[6];
		else if (state != next_state)
			sda_rel <= 1'b1;
	end

	// R12: holding copied into the shifter as each data word begins
	// R9: data pin bits shift into the receiver at each high phase end in ST_BITS
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			transmit_shifter <= 8'h00;
			receive_shifter  <= 8'h00;
			bits_left        <= 4'h0;
		end else if (enter_bits) begin
			transmit_shifter <= next_shift;
			bits_left        <= (next_kind == WK_DATA) ? data_len
			                    : `DATA_BITS;
		end else if (state == ST_BITS && high_end) begin
			transmit_shifter <= {transmit_shifter[6:0], 1'b0};
			// R10: short words land right-aligned, older bits above
			receive_shifter  <= {receive_shifter[6:0], sda_s};
			bits_left        <= bits_left - 4'h1;
		end
	end

	////////////////////////////////////////////////////////////////////
	// R5: hidden counter loads on write and counts words down
	// R7: zero count loads full range
	// R20: every START reloads from the visible count
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i)
			hidden_cnt <= `CNT_FULL;
		else if (wr_cnt)
			hidden_cnt <= count_start(reg_req_i.wdata[15:0]);
		else if (next_state == ST_START && state != ST_START)
			hidden_cnt <= count_start(word_count);
		else if (data_end)
			hidden_cnt <= hidden_cnt - 17'h00001;
	end

	// R19: access ready set at count end, cleared on a repeated START or when disabled
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			access_ready_o <= 1'b0;
			busy_o         <= 1'b0;
		end else begin
			access_ready_o <= enabled && (data_end && next_state == ST_HOLD
			                  || access_ready_o && next_state != ST_RSTART);
			busy_o         <= enabled && next_state != ST_IDLE;
		end
	end

	////////////////////////////////////////////////////////////////////
	// R9: completed words pass the buffer into the holding register
	two_entry_buffer #(
		.WIDTH(8)
	) u_rx_buffer (
		.clock_i    (clock_i),
		.rst_i      (rst_i),
		.in_valid_i (buf_push),
		.in_ready_o (buf_in_ready),
		.in_data_i  (receive_shifter),
		.out_valid_o(buf_out_valid),
		.out_ready_i(!rx_full || rd_rx),
		.out_data_o (buf_out_data)
	);

	// New word wins over a read in the same cycle
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			receive_holding <= 8'h00;
			rx_full         <= 1'b0;
		end else if (buf_pop) begin
			receive_holding <= buf_out_data;
			rx_full         <= 1'b1;
		end else if (rd_rx) begin
			rx_full         <= 1'b0;
		end
	end
	assign rx_ready_o = rx_full;

	////////////////////////////////////////////////////////////////////
	logic [16:0] hi_cyc;
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i)
			hi_cyc <= 17'h00000;
		else if (!scl_lvl || !running || high_end)
			hi_cyc <= 17'h00000;
		else
			hi_cyc <= hi_cyc + 17'h00001;
	end

	default clocking cb @(posedge clock_i); endclocking
	default disable iff (rst_i || !enabled);

	low_phase_a: assert property ( // R2
		$rose(scl_lvl) |-> ($past(ph_cnt) == low_len - 17'h00001)
		&& ($past(scl_lvl, 2) == 1'b0))
		else $error("low phase length wrong");
	high_phase_a: assert property ( // R3
		$fell(scl_lvl) && $past(running) |->
		$past(hi_cyc) == high_len - 17'h00001)
		else $error("high phase length wrong");
	scl_master_a: assert property ( // R1
		!scl_oe_n_o |-> state != ST_IDLE && $past(state) != ST_IDLE
		|| $past(start_go))
		else $error("clock driven while not mastering");
	cnt_load_a: assert property ( // R7
		wr_cnt |=> hidden_cnt == (($past(reg_req_i.wdata[15:0]) == 16'h0000)
		? `CNT_FULL : {1'b0, $past(reg_req_i.wdata[15:0])}))
		else $error("hidden count load wrong");
	cnt_dec_a: assert property ( // R5
		data_end && !wr_cnt && !wr_low |=>
		hidden_cnt == $past(hidden_cnt) - 17'h00001 && $stable(word_count))
		else $error("hidden count step wrong");
	stop_end_a: assert property ( // R6
		data_end && last_word && mode_i.stop_request |=> state == ST_STOP
		##1 !sda_oe_n_o)
		else $error("no stop after last word");
	access_ready_flag_set_a: assert property ( // R19
		data_end && last_word && !mode_i.stop_request |=>
		access_ready_o && state == ST_HOLD)
		else $error("access ready not raised");
	repeat_on_a: assert property ( // R8
		data_end && mode_i.repeat_select && !mode_i.stop_request |=>
		state == ST_BITS && kind == WK_DATA)
		else $error("repeat mode stopped on count");
	addr_seven_a: assert property ( // R16
		enter_bits && next_kind == WK_ADDR1
		&& !mode_i.ten_bit_address_select |=>
		transmit_shifter[7:1] == $past(target_address[6:0]))
		else $error("seven-bit address wrong");
	rx_copy_a: assert property ( // R9
		buf_push && !rx_full && !buf_out_valid && !rd_rx |->
		##2 rx_ready_o && receive_holding == $past(receive_shifter, 2))
		else $error("received word not copied");

	stop_seen_c: cover property (state == ST_STOP ##1 state == ST_IDLE);
	hold_seen_c: cover property (state == ST_HOLD ##1 state == ST_RSTART);
	ten_bit_c:   cover property (kind == WK_ADDR2 && state == ST_ACK);
	rx_stall_c:  cover property (stall);
endmodule

// >>> logic/i2c_defs.svh
// Register indices, field constants and reset values for the data path
`ifndef I2C_DEFS_SVH
`define I2C_DEFS_SVH
`define REG_LOW_DIV    3'h0
`define REG_HIGH_DIV   3'h1
`define REG_WORD_CNT   3'h2
`define REG_RX_HOLD    3'h3
`define REG_TARGET     3'h4
`define REG_TX_HOLD    3'h5
`define DIV_RESET      16'h0000
`define CNT_RESET      16'h0000
`define PHASE_EXTRA    17'h00006
`define CNT_FULL       17'h10000
`define DATA_BITS      4'h8
`define TEN_BIT_PREFIX 5'h1E
`endif

// >>> logic/i2c_pkg.sv
// Types shared by the data path modules
package i2c_pkg;
	typedef struct packed {
		logic       module_reset_bit;
		logic       master_select;
		logic       transmit_select;
		logic       repeat_select;
		logic       stop_request;
		logic       ten_bit_address_select;
		logic       free_format_select;
		logic [2:0] word_bit_count;
	} mode_control_t;
	typedef struct packed {
		logic [2:0]  sel;
		logic        wr;
		logic        rd;
		logic [31:0] wdata;
	} reg_req_t;
	typedef enum logic [2:0] {
		ST_IDLE   = 3'b000,
		ST_START  = 3'b001,
		ST_RSTART = 3'b010,
		ST_BITS   = 3'b011,
		ST_ACK    = 3'b100,
		ST_STOP   = 3'b101,
		ST_HOLD   = 3'b110
	} eng_state_t;
	typedef enum logic [1:0] {
		WK_ADDR1 = 2'b00,
		WK_ADDR2 = 2'b01,
		WK_DATA  = 2'b10
	} word_kind_t;
endpackage

// >>> logic/two_entry_buffer.sv
// Two-entry valid/ready buffer
`timescale 1ns/100ps
module two_entry_buffer #(
	parameter int WIDTH = 8
) (
	input  wire logic             clock_i,
	input  wire logic             rst_i,
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	input  wire logic [WIDTH-1:0] in_data_i,
	output logic                  out_valid_o,
	input  wire logic             out_ready_i,
	output logic      [WIDTH-1:0] out_data_o
);
	logic [WIDTH-1:0] slot [2];
	logic             rd_ptr;
	logic             wr_ptr;
	logic [1:0]       fill;
	wire              push = in_valid_i & in_ready_o;
	wire              pop  = out_valid_o & out_ready_i;

	assign in_ready_o  = (fill != 2'h2);
	assign out_valid_o = (fill != 2'h0);
	assign out_data_o  = slot[rd_ptr];

	always_ff @(posedge clock_i) begin
		if (push)
			slot[wr_ptr] <= in_data_i;
	end

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			rd_ptr <= 1'b0;
			wr_ptr <= 1'b0;
			fill   <= 2'h0;
		end else begin
			rd_ptr <= rd_ptr ^ pop;
			wr_ptr <= wr_ptr ^ push;
			fill   <= fill + {1'b0, push} - {1'b0, pop};
		end
	end
endmodule

// >>> verification/i2c_slave_model.sv
// Behavioural two-wire bus target: acks written bytes, answers reads
`timescale 1ns/100ps
module i2c_slave_model (
	input  wire logic       scl_i,
	input  wire logic       sda_i,
	input  wire logic [3:0] word_bits_i,
	input  wire logic [1:0] addr_bytes_i,
	input  wire logic [7:0] read_data_i,
	output logic            sda_oe_n_o
);
	logic [7:0] got [$];
	logic [7:0] sh;
	logic       on;
	logic       rd;
	int         bitn;
	int         k;

	////////////////////////////////////////////////////////////////////////
	// Address bytes are always 8 bits, data words follow the bit count
	function automatic int wlen();
		return (k < int'(addr_bytes_i)) ? 8 : int'(word_bits_i);
	endfunction

	initial begin
		sda_oe_n_o = 1'b1;
		on = 1'b0;
		rd = 1'b0;
		bitn = 0;
		k = 0;
		sh = 8'h00;
	end

	////////////////////////////////////////////////////////////////////////
	// Start and stop seen as data edges while the clock is high
	// Let a clock fall in the same step settle, so it is no start
	always @(negedge sda_i) begin
		#1;
		if (scl_i === 1'b1) begin
			on = 1'b1;
			bitn = -1;
			k = 0;
			rd = 1'b0;
		end
	end
	always @(posedge sda_i) begin
		#1;
		if (scl_i === 1'b1) begin
			on = 1'b0;
		end
	end

	always @(posedge scl_i) begin
		if (on && bitn >= 0 && bitn < wlen()) begin
			sh = {sh[6:0], sda_i};
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Data changes only while the clock is low; released line floats high
	always @(negedge scl_i) begin
		if (on) begin
			bitn++;
			if (bitn == wlen() + 1) begin
				if (k == 0) begin
					rd = sh[0];
				end
				k++;
				bitn = 0;
			end
			if (bitn == wlen() && (!rd || k < int'(addr_bytes_i))) begin
				got.push_back(sh);
				sda_oe_n_o = 1'b0;
			end else if (rd && k >= int'(addr_bytes_i) && bitn < wlen()) begin
				sda_oe_n_o = read_data_i[wlen() - 1 - bitn];
			end else begin
				sda_oe_n_o = 1'b1;
			end
		end
	end
endmodule

// >>> verification/i2c_clock_count_data_path_tb_top.sv
// Testbench for the two-wire clock, count and data path
`timescale 1ns/100ps
`include "i2c_defs.svh"
module i2c_clock_count_data_path_tb_top;
	import i2c_pkg::*;
	logic          clk;
	logic          rst;
	reg_req_t      req;
	mode_control_t mode;
	logic          start;
	logic [31:0]   rdata;
	logic [31:0]   v;
	logic          scl_oe_n;
	logic          sda_oe_n;
	logic          peer_oe_n;
	logic          access_ready;
	logic          rx_ready;
	logic          busy;
	logic          scl_w;
	logic          sda_w;
	logic          scl_q;
	logic          scl_drv;
	logic          sda_drv;
	logic [3:0]    peer_bits;
	logic [1:0]    peer_addr;
	int            n_fail;
	int            total_checks;
	int            run;
	int            last_lo;
	int            last_hi;

	// Both lines are open drain with pull-ups
	assign scl_w = scl_oe_n;
	assign sda_w = sda_oe_n & peer_oe_n;

	i2c_clock_count_data_path dut (
		.clock_i        (clk),
		.rst_i          (rst),
		.reg_req_i      (req),
		.reg_rdata_o    (rdata),
		.mode_i         (mode),
		.start_request_i(start),
		.scl_i          (scl_w),
		.scl_o          (scl_drv),
		.scl_oe_n_o     (scl_oe_n),
		.sda_i          (sda_w),
		.sda_o          (sda_drv),
		.sda_oe_n_o     (sda_oe_n),
		.access_ready_o (access_ready),
		.rx_ready_o     (rx_ready),
		.busy_o         (busy)
	);

	i2c_slave_model peer (
		.scl_i       (scl_w),
		.sda_i       (sda_w),
		.word_bits_i (peer_bits),
		.addr_bytes_i(peer_addr),
		.read_data_i (8'h05),
		.sda_oe_n_o  (peer_oe_n)
	);

	initial begin
		clk = 1'b0;
	end
	always #2.5 clk = ~clk;

	////////////////////////////////////////////////////////////////////////
	// Length of the last finished low and high clock phases
	always @(posedge clk) begin
		if (scl_w !== scl_q) begin
			if (scl_q) begin
				last_hi = run;
			end else begin
				last_lo = run;
			end
			run = 1;
		end else begin
			run++;
		end
		scl_q = scl_w;
	end

	////////////////////////////////////////////////////////////////////////
	task automatic step();
		@(posedge clk);
		#1;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic report_and_stop();
		if (n_fail == 0 && total_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// Strobes drop for a cycle so no task re-raises one in the same step
	task automatic wr(input logic [2:0] s, input logic [31:0] d);
		req.sel = s;
		req.wr = 1'b1;
		req.wdata = d;
		step();
		req.wr = 1'b0;
		step();
	endtask

	task automatic rd(input logic [2:0] s);
		req.sel = s;
		req.rd = 1'b1;
		step();
		req.rd = 1'b0;
		v = rdata;
		step();
	endtask

	task automatic go();
		start = 1'b1;
		step();
		start = 1'b0;
		step();
	endtask

	task automatic wait_for(input int which);
		int i;
		for (i = 0; i < 20000; i++) begin
			if (which == 0 && busy === 1'b0) break;
			if (which == 1 && access_ready === 1'b1) break;
			if (which == 2 && rx_ready === 1'b1) break;
			if (which == 3 && peer.got.size() >= 3) break;
			step();
		end
		if (i == 20000) begin
			n_fail++;
			$display("MISMATCH t=%0t wait ran out", $time);
			report_and_stop();
		end
	endtask

	////////////////////////////////////////////////////////////////////////
	task automatic t_regs();
		logic [31:0] keep [8];
		keep = '{32'hFFFF, 32'hFFFF, 32'hFFFF, 32'h0, 32'h3FF, 32'hFF,
			32'h0, 32'h0};
		for (int i = 0; i < 4; i++) begin
			rd(3'(i));
			chk(v, 32'h0);
		end
		for (int i = 0; i < 8; i++) begin
			wr(3'(i), 32'hFFFF_FFFF);
			rd(3'(i));
			chk(v, keep[i]);
		end
	endtask

	task automatic t_tx7();
		mode = '0;
		wr(`REG_LOW_DIV, 32'h2);
		wr(`REG_HIGH_DIV, 32'h3);
		wr(`REG_WORD_CNT, 32'h1);
		wr(`REG_TARGET, 32'h3FF);
		wr(`REG_TX_HOLD, 32'hA5);
		peer.got.delete();
		mode = '{module_reset_bit: 1'b1, master_select: 1'b1,
			transmit_select: 1'b1, stop_request: 1'b1, default: '0};
		go();
		wait_for(0);
		chk(32'(peer.got.size()), 32'h2);
		chk({24'h0, peer.got[0]}, 32'hFE);
		chk({24'h0, peer.got[1]}, 32'hA5);
		chk({30'h0, scl_w, sda_w}, 32'h3);
		chk(32'(last_lo), 32'h8);
		chk(32'(last_hi), 32'h9);
		rd(`REG_WORD_CNT);
		chk(v, 32'h1);
	endtask

	task automatic t_rx_short();
		mode = '0;
		wr(`REG_TARGET, 32'h0);
		peer.got.delete();
		peer_bits = 4'h3;
		mode = '{module_reset_bit: 1'b1, master_select: 1'b1,
			word_bit_count: 3'h3, default: '0};
		go();
		wait_for(1);
		wait_for(2);
		chk({24'h0, peer.got[0]}, 32'h01);
		rd(`REG_RX_HOLD);
		chk({29'h0, v[2:0]}, 32'h5);
		chk({31'h0, rx_ready}, 32'h0);
		chk({31'h0, busy}, 32'h1);
		// Disabling releases the held clock here; a start or stop request also leaves hold
		mode.module_reset_bit = 1'b0;
		step();
		step();
		chk({30'h0, scl_w, access_ready}, 32'h2);
	endtask

	task automatic t_tx10();
		mode = '0;
		wr(`REG_TARGET, 32'h2A5);
		wr(`REG_TX_HOLD, 32'h3C);
		peer.got.delete();
		peer_bits = 4'h8;
		peer_addr = 2'h2;
		mode = '{module_reset_bit: 1'b1, master_select: 1'b1,
			transmit_select: 1'b1, stop_request: 1'b1,
			ten_bit_address_select: 1'b1, default: '0};
		go();
		wait_for(0);
		chk(32'(peer.got.size()), 32'h3);
		chk({24'h0, peer.got[0]}, 32'hF4);
		chk({24'h0, peer.got[1]}, 32'hA5);
		chk({24'h0, peer.got[2]}, 32'h3C);
	endtask

	task automatic t_repeat_free();
		mode = '{module_reset_bit: 1'b1, master_select: 1'b1,
			transmit_select: 1'b1, repeat_select: 1'b1,
			free_format_select: 1'b1, word_bit_count: 3'h4,
			default: '0};
		wr(`REG_WORD_CNT, 32'h0);
		wr(`REG_WORD_CNT, 32'h1);
		wr(`REG_TX_HOLD, 32'hA);
		peer.got.delete();
		peer_bits = 4'h4;
		peer_addr = 2'h0;
		go();
		wait_for(3);
		mode.stop_request = 1'b1;
		wait_for(0);
		chk(32'(peer.got.size()), 32'h3);
		chk({28'h0, peer.got[0][3:0]}, 32'hA);
		chk({28'h0, peer.got[2][3:0]}, 32'hA);
		chk({30'h0, scl_drv, sda_drv}, 32'h0);
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		rst = 1'b1;
		req = '0;
		mode = '0;
		start = 1'b0;
		peer_bits = 4'h8;
		peer_addr = 2'h1;
		n_fail = 0;
		total_checks = 0;
		run = 0;
		scl_q = 1'b1;
		repeat (3) @(posedge clk);
		#1;
		rst = 1'b0;
		t_regs();
		t_tx7();
		t_rx_short();
		t_tx10();
		t_repeat_free();
		report_and_stop();
	end
endmodule
